// ---- spucr_pkg.sv ----
/*
 package for the serial port upper configuration register bank.
 holds byte offsets, field positions, reset values and the protect key.
 assumes a 32-bit register bus with word-aligned registers.
*/
package spucr_pkg;
   // byte offsets of the registers held in this bank
   localparam logic [7:0] OFS_ERROR_COUNT = 8'h44;
   localparam logic [7:0] OFS_INFRARED_FILTER = 8'h4C;
   localparam logic [7:0] OFS_MANCHESTER_CONFIG = 8'h50;
   localparam logic [7:0] OFS_LIN_MODE = 8'h54;
   localparam logic [7:0] OFS_LIN_IDENTIFIER = 8'h58;
   localparam logic [7:0] OFS_WRITE_PROTECT_MODE = 8'hE4;
   localparam logic [7:0] OFS_WRITE_PROTECT_STATUS = 8'hE8;
   // protected registers living outside this bank
   localparam logic [7:0] OFS_MODE = 8'h04;
   localparam logic [7:0] OFS_BAUD_GEN = 8'h20;
   localparam logic [7:0] OFS_RX_TIMEOUT = 8'h24;
   localparam logic [7:0] OFS_TX_TIMEGUARD = 8'h28;
   localparam logic [7:0] OFS_CARD_RATIO = 8'h40;
   // reset values
   localparam logic [31:0] RST_MANCHESTER_CONFIG = 32'h30011004;
   localparam logic [31:0] RST_ZERO = 32'h00000000;
   // manchester configuration field positions
   localparam int MAN_DRIFT = 30;
   localparam int MAN_RX_POL = 28;
   localparam int MAN_RX_PREAMBLE_PATTERN_LO = 24;
   localparam int MAN_RX_PREAMBLE_LENGTH_LO = 16;
   localparam int MAN_TX_POL = 12;
   localparam int MAN_TX_PREAMBLE_PATTERN_LO = 8;
   localparam int MAN_TX_PREAMBLE_LENGTH_LO = 0;
   localparam logic [31:0] MAN_WMASK = 32'h530F130F;
   // lin mode field positions
   localparam int LIN_DMA = 16;
   localparam int LIN_LEN_LO = 8;
   localparam int LIN_WAKE = 7;
   localparam int LIN_FRAME_SLOT_DISABLE = 6;
   localparam int LIN_LSEL = 5;
   localparam int LIN_CHKK = 4;
   localparam int LIN_CHKD = 3;
   localparam int LIN_PARD = 2;
   localparam int LIN_NODE_ACTION_LO = 0;
   localparam logic [31:0] LIN_WMASK = 32'h0001FFFF;
   // write protect
   localparam logic [23:0] PROTECT_KEY = 24'h555341;
   localparam int WP_KEY_LO = 8;
   localparam int WPS_SRC_LO = 8;
   // axi response codes
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : spucr_pkg

// ---- spucr_regs.sv ----
/*
 upper configuration and status register bank of a multi-mode serial port,
 reached over an axi4-lite slave. assumes the shifters, baud generator and
 main mode logic sit outside and use the decoded fields below.
*/
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/100ps
module spucr_regs (
   input wire logic mclk, // bus clock, 20 mhz
   input wire logic rst, // asynchronous reset, active high
   input wire logic [7:0] s_axi_awaddr, // write address
   input wire logic s_axi_awvalid, // write address valid
   output logic s_axi_awready, // write address ready
   input wire logic [31:0] s_axi_wdata, // write data
   input wire logic [3:0] s_axi_wstrb, // write byte strobes
   input wire logic s_axi_wvalid, // write data valid
   output logic s_axi_wready, // write data ready
   output logic [1:0] s_axi_bresp, // write response
   output logic s_axi_bvalid, // write response valid
   input wire logic s_axi_bready, // write response ready
   input wire logic [7:0] s_axi_araddr, // read address
   input wire logic s_axi_arvalid, // read address valid
   output logic s_axi_arready, // read address ready
   output logic [31:0] s_axi_rdata, // read data
   output logic [1:0] s_axi_rresp, // read response
   output logic s_axi_rvalid, // read data valid
   input wire logic s_axi_rready, // read data ready
   input wire logic card_error, // one-cycle pulse per smart-card error
   input wire logic lin_master, // high in lin master mode
   input wire logic id_rx_valid, // pulse: identifier received as slave
   input wire logic [7:0] id_rx_char, // received identifier
   input wire logic dma_lin_we, // pulse: dma write to lin mode
   input wire logic [31:0] dma_lin_data, // dma data for lin mode
   input wire logic ext_wr_pulse, // pulse: write to an outside register
   input wire logic [7:0] ext_wr_ofs, // offset of that outside write
   output logic ext_wr_block, // outside write to be discarded
   output logic protect_enable, // write protection on
   output logic [7:0] ir_filter, // infrared demodulator filter
   output logic drift_enable, // drift recovery enabled
   output logic rx_coding_polarity, // receive manchester polarity
   output logic tx_coding_polarity, // transmit manchester polarity
   output logic [1:0] rx_preamble_pattern, // receive preamble pattern
   output logic [1:0] tx_preamble_pattern, // transmit preamble pattern
   output logic [3:0] rx_preamble_length, // receive preamble length
   output logic [3:0] tx_preamble_length, // transmit preamble length
   output logic rx_preamble_on, // preamble detection active
   output logic tx_preamble_on, // preamble generation active
   output logic [8:0] response_bytes, // lin response length in bytes
   output logic wakeup_kind, // 0 lin 2.0 wakeup, 1 lin 1.3 wakeup
   output logic frame_slot_on, // frame slot mode active
   output logic enhanced_checksum, // checksum covers identifier
   output logic checksum_on, // checksum generated and checked
   output logic parity_on, // identifier parity generated and checked
   output logic [1:0] node_action, // publish, subscribe, ignore
   output logic dma_loads_lin_mode, // dma updates lin mode
   output logic [7:0] identifier_char // identifier for the shifters
);
   logic [7:0] error_total_r;
   logic [7:0] ir_filter_r;
   logic [31:0] man_r;
   logic [31:0] lin_r;
   logic [7:0] id_r;
   logic wp_en_r;
   logic viol_r;
   logic [15:0] viol_src_r;
   logic [7:0] awaddr_r;
   logic [31:0] wdata_r;
   logic [3:0] wstrb_r;
   logic aw_held_r;
   logic w_held_r;
   logic [31:0] be_mask;
   logic wr_go;
   logic rd_go;
   logic wr_blocked;
   logic [31:0] rd_val;
   logic [1:0] rd_resp;
   logic [31:0] man_nxt;
   logic [31:0] lin_nxt;

   // byte strobes widened to a bit mask
   assign be_mask = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
   assign wr_go = aw_held_r && w_held_r && !s_axi_bvalid;
   assign rd_go = s_axi_arvalid && s_axi_arready;
   // a write to a protected register in this bank is rejected
   assign wr_blocked = wp_en_r && ((awaddr_r == spucr_pkg::OFS_INFRARED_FILTER) ||
      (awaddr_r == spucr_pkg::OFS_MANCHESTER_CONFIG));
   assign man_nxt = (man_r & ~(be_mask & spucr_pkg::MAN_WMASK)) |
      (wdata_r & be_mask & spucr_pkg::MAN_WMASK);
   assign lin_nxt = (lin_r & ~(be_mask & spucr_pkg::LIN_WMASK)) |
      (wdata_r & be_mask & spucr_pkg::LIN_WMASK);

   // write address and data captured independently, in either order
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         aw_held_r <= 1'b0;
         w_held_r <= 1'b0;
         awaddr_r <= 8'h00;
         wdata_r <= 32'h00000000;
         wstrb_r <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_r <= 1'b1;
            awaddr_r <= {s_axi_awaddr[7:2], 2'h0};
         end else if (wr_go) begin
            aw_held_r <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_r <= 1'b1;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
         end else if (wr_go) begin
            w_held_r <= 1'b0;
         end
      end
   end

   // ready flags and write response
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= spucr_pkg::RESP_OKAY;
      end else begin
         s_axi_awready <= !aw_held_r && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
         s_axi_wready <= !w_held_r && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
         if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            case (awaddr_r)
               spucr_pkg::OFS_ERROR_COUNT, spucr_pkg::OFS_INFRARED_FILTER,
               spucr_pkg::OFS_MANCHESTER_CONFIG, spucr_pkg::OFS_LIN_MODE,
               spucr_pkg::OFS_LIN_IDENTIFIER, spucr_pkg::OFS_WRITE_PROTECT_MODE,
               spucr_pkg::OFS_WRITE_PROTECT_STATUS: s_axi_bresp <= spucr_pkg::RESP_OKAY;
               default: s_axi_bresp <= spucr_pkg::RESP_SLVERR;
            endcase
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // read mux; key field and reserved bits read as zero, except manchester bit 29, which keeps its reset one
   always_comb begin
      rd_val = 32'h00000000;
      rd_resp = spucr_pkg::RESP_OKAY;
      case ({s_axi_araddr[7:2], 2'h0})
         spucr_pkg::OFS_ERROR_COUNT: rd_val[7:0] = error_total_r;
         spucr_pkg::OFS_INFRARED_FILTER: rd_val[7:0] = ir_filter_r;
         spucr_pkg::OFS_MANCHESTER_CONFIG: rd_val = man_r;
         spucr_pkg::OFS_LIN_MODE: rd_val = lin_r;
         spucr_pkg::OFS_LIN_IDENTIFIER: rd_val[7:0] = id_r;
         spucr_pkg::OFS_WRITE_PROTECT_MODE: rd_val[0] = wp_en_r;
         spucr_pkg::OFS_WRITE_PROTECT_STATUS: rd_val = {8'h00, viol_src_r, 7'h00, viol_r};
         default: rd_resp = spucr_pkg::RESP_SLVERR;
      endcase
   end

   // read channel: one cycle from address to data
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= spucr_pkg::RESP_OKAY;
      end else begin
         s_axi_arready <= !s_axi_rvalid && !rd_go;
         if (rd_go) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_val;
            s_axi_rresp <= rd_resp;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // error counter: a new error wins over the clear of a read
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         error_total_r <= 8'h00;
      end else if (card_error) begin
         if (rd_go && s_axi_araddr[7:2] == spucr_pkg::OFS_ERROR_COUNT[7:2]) begin
            error_total_r <= 8'h01;
         end else begin
            error_total_r <= error_total_r + 8'h01;
         end
      end else if (rd_go && s_axi_araddr[7:2] == spucr_pkg::OFS_ERROR_COUNT[7:2]) begin
         error_total_r <= 8'h00;
      end
   end

   // infrared filter and manchester configuration, held when protected
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         ir_filter_r <= 8'h00;
         man_r <= spucr_pkg::RST_MANCHESTER_CONFIG;
      end else if (wr_go && !wr_blocked) begin
         if (awaddr_r == spucr_pkg::OFS_INFRARED_FILTER && wstrb_r[0]) begin
            ir_filter_r <= wdata_r[7:0];
         end
         if (awaddr_r == spucr_pkg::OFS_MANCHESTER_CONFIG) begin
            man_r <= man_nxt;
         end
      end
   end

   // lin mode: bus writes, or dma loads all but the dma bit
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         lin_r <= spucr_pkg::RST_ZERO;
      end else if (wr_go && awaddr_r == spucr_pkg::OFS_LIN_MODE) begin
         lin_r <= lin_nxt;
      end else if (dma_lin_we && lin_r[spucr_pkg::LIN_DMA]) begin
         lin_r <= {15'h0000, lin_r[spucr_pkg::LIN_DMA], dma_lin_data[15:0]};
      end
   end

   // identifier: software in master mode, receiver in slave mode
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         id_r <= 8'h00;
      end else if (!lin_master && id_rx_valid) begin
         id_r <= id_rx_char;
      end else if (lin_master && wr_go && wstrb_r[0] &&
            awaddr_r == spucr_pkg::OFS_LIN_IDENTIFIER) begin
         id_r <= wdata_r[7:0];
      end
   end

   // protect enable changes only with the key in the same write
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         wp_en_r <= 1'b0;
      end else if (wr_go && awaddr_r == spucr_pkg::OFS_WRITE_PROTECT_MODE &&
            wdata_r[31:spucr_pkg::WP_KEY_LO] == spucr_pkg::PROTECT_KEY && wstrb_r == 4'hF) begin
         wp_en_r <= wdata_r[0];
      end
   end

   // violation status: a new violation wins over the clearing read
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         viol_r <= 1'b0;
         viol_src_r <= 16'h0000;
      end else if (wr_go && wr_blocked) begin
         viol_r <= 1'b1;
         viol_src_r <= {8'h00, awaddr_r};
      end else if (ext_wr_pulse && ext_wr_block) begin
         viol_r <= 1'b1;
         viol_src_r <= {8'h00, ext_wr_ofs};
      end else if (rd_go && s_axi_araddr[7:2] == spucr_pkg::OFS_WRITE_PROTECT_STATUS[7:2]) begin
         viol_r <= 1'b0;
         viol_src_r <= 16'h0000;
      end
   end

   // decoded fields to the rest of the port, all registered
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         ext_wr_block <= 1'b0;
         protect_enable <= 1'b0;
         ir_filter <= 8'h00;
         drift_enable <= 1'b0;
         rx_coding_polarity <= 1'b0;
         tx_coding_polarity <= 1'b0;
         rx_preamble_pattern <= 2'h0;
         tx_preamble_pattern <= 2'h0;
         rx_preamble_length <= 4'h0;
         tx_preamble_length <= 4'h0;
         rx_preamble_on <= 1'b0;
         tx_preamble_on <= 1'b0;
         response_bytes <= 9'h001;
         wakeup_kind <= 1'b0;
         frame_slot_on <= 1'b0;
         enhanced_checksum <= 1'b0;
         checksum_on <= 1'b0;
         parity_on <= 1'b0;
         node_action <= 2'h0;
         dma_loads_lin_mode <= 1'b0;
         identifier_char <= 8'h00;
      end else begin
         ext_wr_block <= wp_en_r && (ext_wr_ofs == spucr_pkg::OFS_MODE ||
            ext_wr_ofs == spucr_pkg::OFS_BAUD_GEN || ext_wr_ofs == spucr_pkg::OFS_RX_TIMEOUT ||
            ext_wr_ofs == spucr_pkg::OFS_TX_TIMEGUARD ||
            ext_wr_ofs == spucr_pkg::OFS_CARD_RATIO);
         protect_enable <= wp_en_r;
         ir_filter <= ir_filter_r;
         drift_enable <= man_r[spucr_pkg::MAN_DRIFT];
         rx_coding_polarity <= man_r[spucr_pkg::MAN_RX_POL];
         tx_coding_polarity <= man_r[spucr_pkg::MAN_TX_POL];
         rx_preamble_pattern <= man_r[spucr_pkg::MAN_RX_PREAMBLE_PATTERN_LO +: 2];
         tx_preamble_pattern <= man_r[spucr_pkg::MAN_TX_PREAMBLE_PATTERN_LO +: 2];
         rx_preamble_length <= man_r[spucr_pkg::MAN_RX_PREAMBLE_LENGTH_LO +: 4];
         tx_preamble_length <= man_r[spucr_pkg::MAN_TX_PREAMBLE_LENGTH_LO +: 4];
         rx_preamble_on <= man_r[spucr_pkg::MAN_RX_PREAMBLE_LENGTH_LO +: 4] != 4'h0;
         tx_preamble_on <= man_r[spucr_pkg::MAN_TX_PREAMBLE_LENGTH_LO +: 4] != 4'h0;
         if (lin_r[spucr_pkg::LIN_LSEL]) begin
            case (id_r[5:4])
               2'h0, 2'h1: response_bytes <= 9'h002;
               2'h2: response_bytes <= 9'h004;
               default: response_bytes <= 9'h008;
            endcase
         end else begin
            response_bytes <= {1'b0, lin_r[spucr_pkg::LIN_LEN_LO +: 8]} + 9'h001;
         end
         wakeup_kind <= lin_r[spucr_pkg::LIN_WAKE];
         frame_slot_on <= !lin_r[spucr_pkg::LIN_FRAME_SLOT_DISABLE];
         enhanced_checksum <= !lin_r[spucr_pkg::LIN_CHKK];
         checksum_on <= !lin_r[spucr_pkg::LIN_CHKD];
         parity_on <= !lin_r[spucr_pkg::LIN_PARD];
         node_action <= lin_r[spucr_pkg::LIN_NODE_ACTION_LO +: 2];
         dma_loads_lin_mode <= lin_r[spucr_pkg::LIN_DMA];
         identifier_char <= id_r;
      end
   end
endmodule : spucr_regs

// ---- spucr_regs_props.sv ----
/*
 concurrent checks on the ports of the upper configuration register bank.
 assumes one clock domain, asynchronous active-high reset, bound onto spucr_regs.
*/
`timescale 1ns/100ps
module spucr_regs_props (
   input wire logic mclk, // bus clock
   input wire logic rst, // reset
   input wire logic [1:0] s_axi_bresp, // write response
   input wire logic s_axi_bvalid, // response valid
   input wire logic s_axi_bready, // response ready
   input wire logic [7:0] s_axi_araddr, // read address
   input wire logic s_axi_arvalid, // read address valid
   input wire logic s_axi_arready, // read address ready
   input wire logic [31:0] s_axi_rdata, // read data
   input wire logic s_axi_rvalid, // read valid
   input wire logic s_axi_rready, // read ready
   input wire logic [7:0] ext_wr_ofs, // outside offset
   input wire logic ext_wr_block, // outside write blocked
   input wire logic protect_enable, // protection on
   input wire logic [7:0] ir_filter, // filter setting
   input wire logic drift_enable, // drift recovery
   input wire logic rx_coding_polarity, // rx polarity
   input wire logic tx_coding_polarity, // tx polarity
   input wire logic [3:0] rx_preamble_length, // rx length
   input wire logic [3:0] tx_preamble_length, // tx length
   input wire logic rx_preamble_on, // detection on
   input wire logic tx_preamble_on, // generation on
   input wire logic frame_slot_on, // frame slot mode
   input wire logic [1:0] node_action // node action
);
   default clocking spucr_cb @(posedge mclk);
   endclocking
   default disable iff (rst);
   logic ar_hs;
   // read address taken in this cycle
   assign ar_hs = s_axi_arvalid && s_axi_arready;
   property p_bhold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_bhold: assert property (p_bhold) else $error("write response dropped early");
   property p_rhold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_rhold: assert property (p_rhold) else $error("read data dropped early");
   property p_pre;
      rx_preamble_on == |rx_preamble_length && tx_preamble_on == |tx_preamble_length;
   endproperty
   a_pre: assert property (p_pre) else $error("preamble enable wrong");
   property p_block;
      ext_wr_block |-> protect_enable
         && ($past(ext_wr_ofs) inside {8'h04, 8'h20, 8'h24, 8'h28, 8'h40});
   endproperty
   a_block: assert property (p_block) else $error("outside write blocked wrongly");
   property p_key;
      ar_hs && s_axi_araddr == 8'hE4 |=> s_axi_rvalid && s_axi_rdata[31:8] == 24'h000000;
   endproperty
   a_key: assert property (p_key) else $error("key field not zero");
   property p_filt;
      ar_hs && s_axi_araddr == 8'h4C |=> s_axi_rdata[7:0] == ir_filter;
   endproperty
   a_filt: assert property (p_filt) else $error("filter output differs");
   property p_code;
      ar_hs && s_axi_araddr == 8'h50 |=> s_axi_rdata[30] == drift_enable
         && s_axi_rdata[28] == rx_coding_polarity && s_axi_rdata[12] == tx_coding_polarity;
   endproperty
   a_code: assert property (p_code) else $error("coding outputs differ");
   property p_lin;
      ar_hs && s_axi_araddr == 8'h54 |=> s_axi_rdata[1:0] == node_action
         && s_axi_rdata[6] == !frame_slot_on;
   endproperty
   a_lin: assert property (p_lin) else $error("lin outputs differ");
   property p_wpchg;
      $changed(protect_enable) |-> $past(s_axi_bvalid);
   endproperty
   a_wpchg: assert property (p_wpchg) else $error("protection changed without write");
   c_wp: cover property ($rose(protect_enable));
   c_block: cover property (ext_wr_block);
   c_stat: cover property (ar_hs && s_axi_araddr == 8'hE8);
endmodule : spucr_regs_props
bind spucr_regs spucr_regs_props u_props (.mclk, .rst, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
   .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
   .ext_wr_ofs, .ext_wr_block, .protect_enable, .ir_filter, .drift_enable, .rx_coding_polarity,
   .tx_coding_polarity, .rx_preamble_length, .tx_preamble_length, .rx_preamble_on,
   .tx_preamble_on, .frame_slot_on, .node_action);

// ---- spucr_side_model.sv ----
/*
 far-side model: smart-card error pulses, received identifiers, dma loads
 and outside register writes. assumes the bench calls its tasks.
*/
`timescale 1ns/100ps
module spucr_side_model (
   input wire logic mclk, // bus clock
   output logic card_error, // error pulse
   output logic id_rx_valid, // identifier strobe
   output logic [7:0] id_rx_char, // received identifier
   output logic dma_lin_we, // dma strobe
   output logic [31:0] dma_lin_data, // dma word
   output logic ext_wr_pulse, // outside write strobe
   output logic [7:0] ext_wr_ofs // outside write offset
);
   // idle levels at time zero
   initial begin
      {card_error, id_rx_valid, dma_lin_we, ext_wr_pulse} = 4'h0;
      {id_rx_char, ext_wr_ofs, dma_lin_data} = 48'h0;
   end
   // error pulses with an idle cycle between them
   task automatic errs(input int n);
      repeat (n) begin
         @(posedge mclk);
         card_error <= 1'b1;
         @(posedge mclk);
         card_error <= 1'b0;
      end
   endtask : errs
   // strobed words; data moves away once the strobe drops
   task automatic rx_id(input logic [7:0] c);
      @(posedge mclk);
      id_rx_char <= c;
      id_rx_valid <= 1'b1;
      @(posedge mclk);
      id_rx_valid <= 1'b0;
      id_rx_char <= ~c;
   endtask : rx_id
   task automatic dma(input logic [31:0] d);
      @(posedge mclk);
      dma_lin_data <= d;
      dma_lin_we <= 1'b1;
      @(posedge mclk);
      dma_lin_we <= 1'b0;
      dma_lin_data <= ~d;
   endtask : dma
   // offset is held ahead of the strobe and stays afterwards
   task automatic ext(input logic [7:0] o);
      @(posedge mclk);
      ext_wr_ofs <= o;
      repeat (2) @(posedge mclk);
      ext_wr_pulse <= 1'b1;
      @(posedge mclk);
      ext_wr_pulse <= 1'b0;
   endtask : ext
endmodule : spucr_side_model

// ---- tb_spucr_regs.sv ----
/*
 self-checking bench for the upper configuration register bank.
 assumes the side model and the bound checker; axi4-lite master below.
*/
`timescale 1ns/100ps
module tb_spucr_regs;
   logic mclk = 1'b0, rst = 1'b1, lin_master = 1'b1;
   logic [7:0] s_axi_awaddr, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata;
   logic [3:0] s_axi_wstrb;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, node_action, rx_preamble_pattern, tx_preamble_pattern, rs;
   logic [31:0] s_axi_rdata, dma_lin_data, rd;
   logic card_error, id_rx_valid, dma_lin_we, ext_wr_pulse, ext_wr_block, protect_enable;
   logic [7:0] id_rx_char, ext_wr_ofs, ir_filter, identifier_char;
   logic drift_enable, rx_coding_polarity, tx_coding_polarity, rx_preamble_on, tx_preamble_on;
   logic wakeup_kind, frame_slot_on, enhanced_checksum, checksum_on, parity_on, dma_loads_lin_mode;
   logic [3:0] rx_preamble_length, tx_preamble_length;
   logic [8:0] response_bytes;
   int fails = 0;
   int samples_checked = 0;
   // bus clock, 50 ns period
   always #25 mclk = ~mclk;
   spucr_regs DUT (.mclk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .card_error, .lin_master, .id_rx_valid, .id_rx_char, .dma_lin_we,
      .dma_lin_data, .ext_wr_pulse, .ext_wr_ofs, .ext_wr_block, .protect_enable, .ir_filter,
      .drift_enable, .rx_coding_polarity, .tx_coding_polarity, .rx_preamble_pattern,
      .tx_preamble_pattern, .rx_preamble_length, .tx_preamble_length, .rx_preamble_on,
      .tx_preamble_on, .response_bytes, .wakeup_kind, .frame_slot_on, .enhanced_checksum,
      .checksum_on, .parity_on, .node_action, .dma_loads_lin_mode, .identifier_char);
   spucr_side_model side (.mclk, .card_error, .id_rx_valid, .id_rx_char, .dma_lin_we,
      .dma_lin_data, .ext_wr_pulse, .ext_wr_ofs);
   task automatic complete_run();
      if (fails == 0 && samples_checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : complete_run
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // write: address and data offered together, each released when taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF);
      int n;
      @(posedge mclk);
      s_axi_awaddr <= a;
      {s_axi_wdata, s_axi_wstrb} <= {d, s};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      for (n = 0; n < 40; n++) begin
         @(posedge mclk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) break;
      end
      if (n == 40) begin
         fails++;
         complete_run();
      end
      s_axi_bready <= 1'b0;
      chk(32'(s_axi_bresp), 32'h0);
   endtask : wr
   task automatic rdr(input logic [7:0] a);
      int n;
      @(posedge mclk);
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
      for (n = 0; n < 40; n++) begin
         @(posedge mclk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) break;
      end
      if (n == 40) begin
         fails++;
         complete_run();
      end
      s_axi_rready <= 1'b0;
      rd = s_axi_rdata;
      rs = s_axi_rresp;
   endtask : rdr
   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      rdr(a);
      chk(rd, e);
   endtask : rchk
   // decoded outputs trail the register by one cycle
   task automatic settle();
      repeat (2) @(posedge mclk);
   endtask : settle
   task automatic t_reset();
      logic [7:0] ofs [7] = '{8'h44, 8'h4C, 8'h50, 8'h54, 8'h58, 8'hE4, 8'hE8};
      for (int i = 0; i < 7; i++) rchk(ofs[i], (i == 2) ? 32'h30011004 : 32'h0);
      rdr(8'h60);
      chk(32'(rs), 32'h2); // unmapped place
      chk(32'({rx_preamble_on, tx_preamble_on, frame_slot_on, parity_on}), 32'hF);
   endtask : t_reset
   task automatic t_err();
      side.errs(3);
      rchk(8'h44, 32'h3);
      rchk(8'h44, 32'h0);
   endtask : t_err
   task automatic t_code();
      logic [31:0] w;
      for (int p = 0; p < 4; p++) begin
         w = 32'((p % 2) << 30 | (p / 2) << 28 | p << 24 | p << 16 |
            (1 - p % 2) << 12 | (3 - p) << 8 | (15 - p));
         wr(8'h50, w);
         settle();
         chk(32'({drift_enable, rx_coding_polarity, rx_preamble_pattern, rx_preamble_length,
            rx_preamble_on, tx_coding_polarity, tx_preamble_pattern, tx_preamble_length,
            tx_preamble_on}), 32'({w[30], w[28], w[25:24], w[19:16], |w[19:16], w[12], w[9:8],
            w[3:0], 1'b1}));
         rdr(8'h50);
         chk(rd & 32'h530F130F, w);
      end
   endtask : t_code
   task automatic t_ident();
      wr(8'h58, 32'hA5);
      side.rx_id(8'h77);
      rchk(8'h58, 32'hA5);
      lin_master <= !lin_master;
      wr(8'h58, 32'h11);
      rchk(8'h58, 32'hA5);
      side.rx_id(8'h3C);
      rchk(8'h58, 32'h3C);
      chk(32'(identifier_char), 32'h3C);
      lin_master <= !lin_master;
   endtask : t_ident
   task automatic t_lin();
      logic [31:0] lv [3] = '{32'h0, 32'h0000FFDD, 32'h00004A02};
      for (int k = 0; k < 3; k++) begin
         wr(8'h54, lv[k]);
         settle();
         chk(32'({response_bytes, wakeup_kind, frame_slot_on, enhanced_checksum, checksum_on,
            parity_on, node_action}), 32'({9'(lv[k][15:8]) + 9'h001, lv[k][7], !lv[k][6],
            !lv[k][4], !lv[k][3], !lv[k][2], lv[k][1:0]}));
         rchk(8'h54, lv[k]);
      end
      wr(8'h58, 32'h20);
      wr(8'h54, 32'h20, 4'h1);
      settle();
      chk(32'(response_bytes), 32'h4);
      side.dma(32'h00001234);
      rchk(8'h54, 32'h4A20);
      wr(8'h54, 32'h00010000);
      side.dma(32'h00001234);
      rchk(8'h54, 32'h00011234);
      chk(32'(dma_loads_lin_mode), 32'h1);
   endtask : t_lin
   task automatic t_protect();
      wr(8'h4C, 32'h5A);
      settle();
      chk(32'(ir_filter), 32'h5A);
      wr(8'hE4, 32'h55534001);
      settle();
      chk(32'(protect_enable), 32'h0);
      wr(8'hE4, 32'h55534101);
      settle();
      chk(32'(protect_enable), 32'h1);
      rchk(8'hE4, 32'h1);
      wr(8'h4C, 32'h77);
      rchk(8'h4C, 32'h5A);
      rchk(8'hE8, 32'h00004C01);
      rchk(8'hE8, 32'h0);
      wr(8'h50, 32'h0);
      rchk(8'hE8, 32'h00005001);
      side.ext(8'h20);
      chk(32'(ext_wr_block), 32'h1);
      rchk(8'hE8, 32'h00002001);
      side.ext(8'h30);
      chk(32'(ext_wr_block), 32'h0);
      rchk(8'hE8, 32'h0);
      wr(8'hE4, 32'h55534100);
      wr(8'h4C, 32'h77);
      rchk(8'h4C, 32'h77);
   endtask : t_protect
   // reset for 16 cycles, then each scenario in turn
   initial begin
      repeat (16) @(posedge mclk);
      rst <= 1'b0;
      repeat (3) @(posedge mclk);
      t_reset();
      t_err();
      t_code();
      t_ident();
      t_lin();
      t_protect();
      complete_run();
   end
endmodule : tb_spucr_regs
